// ===== common/urls_pkg.sv
// constants, field positions and trigger decoders for the rts/line-status block
`default_nettype none
package urls_pkg;
   // bus and fifo geometry
   localparam int ADDR_W = 32;
   localparam int DATA_W = 16;
   localparam int DEPTH  = 16;
   localparam int PTR_W  = 4;
   localparam int LVL_W  = 5;
   localparam int MCR_W  = 7;
   localparam int IRQ_W  = 2;
   localparam logic [LVL_W-1:0] DEPTH_LVL = 5'h10;
   localparam logic [LVL_W-1:0] LVL_ZERO  = 5'h00;
   localparam logic [LVL_W-1:0] LVL_ONE   = 5'h01;

   // register byte addresses
   localparam logic [ADDR_W-1:0] IER_ADDR  = 32'h5000_1004;
   localparam logic [ADDR_W-1:0] FCR_ADDR  = 32'h5000_1008;
   localparam logic [ADDR_W-1:0] MCR_ADDR  = 32'h5000_1010;
   localparam logic [ADDR_W-1:0] LSR_ADDR  = 32'h5000_1014;
   localparam logic [ADDR_W-1:0] ISTA_ADDR = 32'h5000_1040;
   localparam logic [ADDR_W-1:0] IMSK_ADDR = 32'h5000_1044;

   // modem_line_control fields
   localparam int MCR_RTS  = 1;
   localparam int MCR_LB   = 4;
   localparam int MCR_AUTO_FLOW_ENABLE = 5;
   // fifo_ctrl fields
   localparam int FCR_FIFO_EN = 0;
   localparam int FCR_TXT_LO  = 4;
   localparam int FCR_RXT_LO  = 6;
   // irq_enable_ctrl fields
   localparam int IER_THRE_EN   = 1;
   localparam int IER_THRE_MODE = 7;
   // line_state_status fields
   localparam int LSR_THRE = 5;
   localparam int LSR_TEMT = 6;
   localparam int LSR_RFE  = 7;
   // interrupt status / mask fields
   localparam int IRQ_THRE = 0;
   localparam int IRQ_RFE  = 1;

   // reset values
   localparam logic [MCR_W-1:0] MCR_RST  = 7'h00;
   localparam logic [7:0]       FCR_RST  = 8'h00;
   localparam logic [7:0]       IER_RST  = 8'h00;
   localparam logic [IRQ_W-1:0] IRQ_RST  = 2'h0;
   localparam logic             THRE_RST = 1'h1;
   localparam logic             TEMT_RST = 1'h1;
   localparam logic             RFE_RST  = 1'h0;

   // receive trigger: 1, quarter, half, two below full
   function automatic logic [LVL_W-1:0] rx_trig(input logic [1:0] sel);
      case (sel)
         2'h0:    rx_trig = 5'h01;
         2'h1:    rx_trig = 5'h04;
         2'h2:    rx_trig = 5'h08;
         default: rx_trig = 5'h0E;
      endcase
   endfunction

   // transmit trigger: empty, two, quarter, half
   function automatic logic [LVL_W-1:0] tx_trig(input logic [1:0] sel);
      case (sel)
         2'h0:    tx_trig = 5'h00;
         2'h1:    tx_trig = 5'h02;
         2'h2:    tx_trig = 5'h04;
         default: tx_trig = 5'h08;
      endcase
   endfunction
endpackage
`default_nettype wire

// ===== rtl/urls_err_track.sv
// receive fifo shadow: per-entry error bits, fill level and error flag
`default_nettype none
module urls_err_track (
   // clock and reset
   input  wire logic                      clk_i,
   input  wire logic                      rst_n_i,
   // receive fifo traffic
   input  wire logic                      push_i,
   input  wire logic                      push_err_i,
   input  wire logic                      pop_i,
   input  wire logic                      fifo_en_i,
   input  wire logic                      lsr_rd_i,
   // state out
   output logic [urls_pkg::LVL_W-1:0]     level_o,
   output logic                           rfe_o
);
   typedef struct packed {
      logic [urls_pkg::DEPTH-1:0] bits;
      logic [urls_pkg::PTR_W-1:0] wp;
      logic [urls_pkg::PTR_W-1:0] rp;
      logic [urls_pkg::LVL_W-1:0] cnt;
      logic [urls_pkg::LVL_W-1:0] ecnt;
      logic                       flag;
   } urls_trk_t;

   localparam urls_trk_t TRK_RST = '{bits: '0, wp: '0, rp: '0,
      cnt: urls_pkg::LVL_ZERO, ecnt: urls_pkg::LVL_ZERO,
      flag: urls_pkg::RFE_RST};

   urls_trk_t s;
   urls_trk_t next_s;
   logic      do_push;
   logic      do_pop;
   logic      err_in;
   logic      err_out;
   logic      set_flag;
   logic      clr_flag;

   // shadow update; a push into a full fifo is an overrun and is dropped
   always_comb begin
      next_s   = s;
      do_push  = push_i && (s.cnt != urls_pkg::DEPTH_LVL);
      do_pop   = pop_i && (s.cnt != urls_pkg::LVL_ZERO);
      err_in   = do_push && push_err_i;
      err_out  = do_pop && s.bits[s.rp];
      set_flag = err_in && fifo_en_i;
      // clear with no error queued, or with the errored entry at the head and none behind it
      clr_flag = lsr_rd_i && ((s.ecnt == urls_pkg::LVL_ZERO) ||
                 (s.bits[s.rp] && (s.ecnt == urls_pkg::LVL_ONE)));
      if (do_push) begin
         next_s.bits[s.wp] = push_err_i;
         next_s.wp         = s.wp + 4'h1;
      end
      if (do_pop) begin
         next_s.rp = s.rp + 4'h1;
      end
      case ({do_push, do_pop})
         2'b10:   next_s.cnt = s.cnt + 5'h01;
         2'b01:   next_s.cnt = s.cnt - 5'h01;
         default: next_s.cnt = s.cnt;
      endcase
      case ({err_in, err_out})
         2'b10:   next_s.ecnt = s.ecnt + 5'h01;
         2'b01:   next_s.ecnt = s.ecnt - 5'h01;
         default: next_s.ecnt = s.ecnt;
      endcase
      // a new error beats a simultaneous read clear
      next_s.flag = set_flag || (s.flag && !clr_flag);
   end

   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         s <= TRK_RST;
      end else begin
         s <= next_s;
      end
   end

   assign level_o = s.cnt;
   assign rfe_o   = s.flag;

   rfe_set_a: assert property (
      @(posedge clk_i) disable iff (!rst_n_i)
      set_flag |=> rfe_o)
      else $error("error flag missed an errored push");
   rfe_hold_a: assert property (
      @(posedge clk_i) disable iff (!rst_n_i)
      lsr_rd_i && rfe_o && (s.ecnt > urls_pkg::LVL_ONE) |=> rfe_o)
      else $error("error flag cleared with errors still queued");
endmodule
`default_nettype wire

// ===== rtl/urls_top.sv
// request-to-send control and upper line-status flags of the serial port
`default_nettype none
module urls_top #(
   parameter bit AUTO_FLOW_OPTION = 1'b1
) (
   // clock and reset
   input  wire logic                        clk_i,
   input  wire logic                        rst_n_i,
   // register port
   input  wire logic [urls_pkg::ADDR_W-1:0] addr_i,
   input  wire logic [urls_pkg::DATA_W-1:0] wdata_i,
   input  wire logic                        wr_i,
   input  wire logic                        rd_i,
   output logic [urls_pkg::DATA_W-1:0]      rdata_o,
   // transmit path state
   input  wire logic [urls_pkg::LVL_W-1:0]  tx_count_i,
   input  wire logic                        tx_shift_busy_i,
   // receive fifo traffic
   input  wire logic                        rx_push_i,
   input  wire logic                        rx_push_err_i,
   input  wire logic                        rx_pop_i,
   // modem side
   output logic                             rts_n_o,
   output logic                             loop_rts_o,
   // interrupt
   output logic                             irq_o
);
   typedef struct packed {
      logic [urls_pkg::MCR_W-1:0]  modem_line_control;
      logic [7:0]                  fifo_ctrl;
      logic [7:0]                  irq_enable_ctrl;
      logic [urls_pkg::IRQ_W-1:0]  stat;
      logic [urls_pkg::IRQ_W-1:0]  mask;
      logic [urls_pkg::DATA_W-1:0] rdata;
      logic                        rts_n;
      logic                        loop_rts;
      logic                        thre;
      logic                        temt;
      logic                        trig_d;
      logic                        rfe_d;
      logic                        irq;
   } urls_state_t;

   localparam urls_state_t ST_RST = '{
      modem_line_control:      urls_pkg::MCR_RST,
      fifo_ctrl:      urls_pkg::FCR_RST,
      irq_enable_ctrl:      urls_pkg::IER_RST,
      stat:     urls_pkg::IRQ_RST,
      mask:     urls_pkg::IRQ_RST,
      rdata:    '0,
      rts_n:    1'h1,
      loop_rts: 1'h0,
      thre:     urls_pkg::THRE_RST,
      temt:     urls_pkg::TEMT_RST,
      trig_d:   1'h1,
      rfe_d:    urls_pkg::RFE_RST,
      irq:      1'h0
   };

   urls_state_t                 s;
   urls_state_t                 next_s;
   logic [urls_pkg::LVL_W-1:0]  rx_level;
   logic                        rfe;
   logic                        lsr_rd;
   logic                        fifo_en;
   logic                        afc_on;
   logic                        thre_mode;
   logic                        hold_empty;
   logic                        tx_full;
   logic                        trig_now;
   logic                        ev_thre;
   logic                        ev_rfe;
   logic                        rx_over;
   logic [urls_pkg::IRQ_W-1:0]  set_v;
   logic [urls_pkg::IRQ_W-1:0]  clr_v;

   // read of line_state_status carries the error-clear side effect
   assign lsr_rd = rd_i && (addr_i == urls_pkg::LSR_ADDR);

   urls_err_track u_trk (
      .clk_i      (clk_i),
      .rst_n_i    (rst_n_i),
      .push_i     (rx_push_i),
      .push_err_i (rx_push_err_i),
      .pop_i      (rx_pop_i),
      .fifo_en_i  (s.fifo_ctrl[urls_pkg::FCR_FIFO_EN]),
      .lsr_rd_i   (lsr_rd),
      .level_o    (rx_level),
      .rfe_o      (rfe)
   );

   // mode decode from the control registers
   always_comb begin
      fifo_en   = s.fifo_ctrl[urls_pkg::FCR_FIFO_EN];
      // auto flow only counts with the fifos on
      afc_on    = s.modem_line_control[urls_pkg::MCR_AUTO_FLOW_ENABLE] && fifo_en;
      thre_mode = s.irq_enable_ctrl[urls_pkg::IER_THRE_MODE] && fifo_en;
      rx_over   = rx_level >
                  urls_pkg::rx_trig(s.fifo_ctrl[urls_pkg::FCR_RXT_LO +: 2]);
      hold_empty = (tx_count_i == urls_pkg::LVL_ZERO);
      tx_full    = (tx_count_i == urls_pkg::DEPTH_LVL);
   end

   // holding-empty trigger: plain empty, or at/below the tx threshold
   always_comb begin
      if (thre_mode) begin
         trig_now = tx_count_i <=
            urls_pkg::tx_trig(s.fifo_ctrl[urls_pkg::FCR_TXT_LO +: 2]);
      end else begin
         trig_now = hold_empty;
      end
      // edge only: a level would re-fire after every write-1 clear
      ev_thre = trig_now && !s.trig_d &&
                s.irq_enable_ctrl[urls_pkg::IER_THRE_EN];
      ev_rfe  = rfe && !s.rfe_d;
   end

   // interrupt set and clear vectors
   always_comb begin
      set_v = '0;
      clr_v = '0;
      set_v[urls_pkg::IRQ_THRE] = ev_thre;
      set_v[urls_pkg::IRQ_RFE]  = ev_rfe;
      if (wr_i && (addr_i == urls_pkg::ISTA_ADDR)) begin
         clr_v = wdata_i[urls_pkg::IRQ_W-1:0];
      end
   end

   // next state of every register of the block except those held in the error tracker
   always_comb begin
      next_s        = s;
      next_s.rdata  = '0;
      next_s.trig_d = trig_now;
      next_s.rfe_d  = rfe;

      // software writes
      if (wr_i) begin
         case (addr_i)
            urls_pkg::MCR_ADDR: begin
               next_s.modem_line_control = wdata_i[urls_pkg::MCR_W-1:0];
               if (!AUTO_FLOW_OPTION) begin
                  next_s.modem_line_control[urls_pkg::MCR_AUTO_FLOW_ENABLE] = 1'h0;
               end
            end
            urls_pkg::FCR_ADDR: begin
               next_s.fifo_ctrl = wdata_i[7:0];
            end
            urls_pkg::IER_ADDR: begin
               next_s.irq_enable_ctrl = wdata_i[7:0];
            end
            urls_pkg::IMSK_ADDR: begin
               next_s.mask = wdata_i[urls_pkg::IRQ_W-1:0];
            end
            default: begin
               next_s.modem_line_control = s.modem_line_control;
            end
         endcase
      end

      // reads answer one cycle later; unmapped reads give zero
      if (rd_i) begin
         case (addr_i)
            urls_pkg::MCR_ADDR: begin
               // stored value, untouched by loopback or gating
               next_s.rdata[urls_pkg::MCR_W-1:0] = s.modem_line_control;
            end
            urls_pkg::LSR_ADDR: begin
               next_s.rdata[urls_pkg::LSR_RFE]  = rfe;
               next_s.rdata[urls_pkg::LSR_TEMT] = s.temt;
               next_s.rdata[urls_pkg::LSR_THRE] = s.thre;
            end
            urls_pkg::FCR_ADDR: begin
               next_s.rdata[7:0] = s.fifo_ctrl;
            end
            urls_pkg::IER_ADDR: begin
               next_s.rdata[7:0] = s.irq_enable_ctrl;
            end
            urls_pkg::ISTA_ADDR: begin
               next_s.rdata[urls_pkg::IRQ_W-1:0] = s.stat;
            end
            urls_pkg::IMSK_ADDR: begin
               next_s.rdata[urls_pkg::IRQ_W-1:0] = s.mask;
            end
            default: begin
               next_s.rdata = '0;
            end
         endcase
      end

      // line-status flags
      next_s.temt = hold_empty && !tx_shift_busy_i;
      next_s.thre = thre_mode ? tx_full : hold_empty;

      // sticky status: an event in the clearing cycle survives
      next_s.stat = (s.stat & ~clr_v) | set_v;
      next_s.irq  = |(next_s.stat & next_s.mask);

      // send-request pin, active low
      if (s.modem_line_control[urls_pkg::MCR_LB]) begin
         next_s.rts_n = 1'h1;
      end else if (!s.modem_line_control[urls_pkg::MCR_RTS]) begin
         next_s.rts_n = 1'h1;
      end else if (afc_on && rx_over) begin
         next_s.rts_n = 1'h1;
      end else begin
         next_s.rts_n = 1'h0;
      end
      // loopback copy toward the modem-input side
      next_s.loop_rts = s.modem_line_control[urls_pkg::MCR_LB] &&
                        s.modem_line_control[urls_pkg::MCR_RTS];
   end

   // single state register; reset leaves both empty flags at one
   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         s <= ST_RST;
      end else begin
         s <= next_s;
      end
   end

   assign rdata_o    = s.rdata;
   assign rts_n_o    = s.rts_n;
   assign loop_rts_o = s.loop_rts;
   assign irq_o      = s.irq;

   // pin behaviour
   rts_drive_a: assert property (
      @(posedge clk_i) disable iff (!rst_n_i)
      !s.modem_line_control[urls_pkg::MCR_LB] && s.modem_line_control[urls_pkg::MCR_RTS] && !afc_on
      |=> !rts_n_o)
      else $error("send-request not asserted by rts bit");
   rts_gate_a: assert property (
      @(posedge clk_i) disable iff (!rst_n_i)
      afc_on && rx_over |=> rts_n_o)
      else $error("send-request not gated by rx threshold");
   rts_off_a: assert property (
      @(posedge clk_i) disable iff (!rst_n_i)
      !s.modem_line_control[urls_pkg::MCR_RTS] |=> rts_n_o)
      else $error("send-request active with rts bit clear");
   loop_hold_a: assert property (
      @(posedge clk_i) disable iff (!rst_n_i)
      s.modem_line_control[urls_pkg::MCR_LB]
      |=> rts_n_o && (loop_rts_o == $past(s.modem_line_control[urls_pkg::MCR_RTS])))
      else $error("loopback did not hold pin or feed back");
   afc_fifo_a: assert property (
      @(posedge clk_i) disable iff (!rst_n_i)
      !fifo_en && s.modem_line_control[urls_pkg::MCR_RTS] && !s.modem_line_control[urls_pkg::MCR_LB]
      |=> !rts_n_o)
      else $error("auto flow active without fifos");

   // status flags, holding-empty interrupt and rts bit readback
   temt_flag_a: assert property (
      @(posedge clk_i) disable iff (!rst_n_i)
      s.temt == $past(hold_empty && !tx_shift_busy_i))
      else $error("transmitter empty flag wrong");
   thre_empty_a: assert property (
      @(posedge clk_i) disable iff (!rst_n_i)
      !thre_mode |=> s.thre == $past(hold_empty))
      else $error("holding empty flag wrong");
   thre_full_a: assert property (
      @(posedge clk_i) disable iff (!rst_n_i)
      thre_mode && tx_full |=> s.thre)
      else $error("threshold mode flag not showing full");
   thre_irq_a: assert property (
      @(posedge clk_i) disable iff (!rst_n_i)
      ev_thre && s.mask[urls_pkg::IRQ_THRE] |=> irq_o)
      else $error("holding empty event raised no interrupt");
   mcr_read_a: assert property (
      @(posedge clk_i) disable iff (!rst_n_i)
      rd_i && (addr_i == urls_pkg::MCR_ADDR)
      |=> rdata_o[urls_pkg::MCR_RTS] == $past(s.modem_line_control[urls_pkg::MCR_RTS]))
      else $error("rts bit readback wrong");

   // main scenarios
   gate_seen_c: cover property (@(posedge clk_i) disable iff (!rst_n_i)
      afc_on && s.modem_line_control[urls_pkg::MCR_RTS] && rx_over ##1 rts_n_o);
   loop_seen_c: cover property (@(posedge clk_i) disable iff (!rst_n_i)
      s.modem_line_control[urls_pkg::MCR_LB] ##1 loop_rts_o);
   rfe_read_c: cover property (@(posedge clk_i) disable iff (!rst_n_i)
      rfe && lsr_rd ##1 !rfe);
   thre_irq_c: cover property (@(posedge clk_i) disable iff (!rst_n_i)
      thre_mode && ev_thre ##1 irq_o);
endmodule
`default_nettype wire

// ===== dv/urls_modem.sv
// modem-side model: delivers characters into the receive fifo
`default_nettype none
module urls_modem (
   // clock and reset
   input  wire logic clk_i,
   input  wire logic rst_n_i,
   // send-request from the port, active low
   input  wire logic rts_n_i,
   // character arrivals
   output var logic  push_o,
   output var logic  push_err_o
);
   timeunit 1ns;
   timeprecision 1ps;

   int sent;

   // quiet line until a call asks for characters
   initial begin
      push_o     = 1'b0;
      push_err_o = 1'b0;
      sent       = 0;
   end

   // one character per pass, gap idle cycles after it; a data set holds
   // off while send-request is inactive and gives up after a long stall
   task automatic send_chars(input int n, input logic [7:0] errs,
                             input int gap);
      int w;
      for (int i = 0; i < n; i++) begin
         w = 0;
         #1;
         while ((rts_n_i !== 1'b0 || !rst_n_i) && w < 200) begin
            @(posedge clk_i);
            #1;
            w++;
         end
         if (w >= 200)
            return;
         @(posedge clk_i);
         push_o     <= 1'b1;
         push_err_o <= errs[i];
         @(posedge clk_i);
         push_o     <= 1'b0;
         push_err_o <= 1'b0;
         sent++;
         repeat (gap) @(posedge clk_i);
      end
   endtask
endmodule
`default_nettype wire

// ===== dv/tb_uart_rts_and_line_status.sv
// self-checking bench for the send-request and line-status block
`default_nettype none
module tb_uart_rts_and_line_status;
   timeunit 1ns;
   timeprecision 1ps;

   typedef struct packed {
      logic [7:0] fifo_ctrl;
      logic [7:0] irq_enable_ctrl;
      logic [7:0] modem_line_control;
      logic [4:0] txc;
      logic       busy;
      logic       rts_n;
      logic       loop;
      logic [2:0] line_state_status;
   } urls_row_t;

   logic        clk_i;
   logic        rst_n_i;
   logic [31:0] addr_i;
   logic [15:0] wdata_i;
   logic        wr_i;
   logic        rd_i;
   logic [15:0] rdata_o;
   logic [4:0]  tx_count_i;
   logic        tx_shift_busy_i;
   logic        rx_push_i;
   logic        rx_push_err_i;
   logic        rx_pop_i;
   logic        rts_n_o;
   logic        loop_rts_o;
   logic        irq_o;
   logic [15:0] rv;
   int          err_total;
   int          total_checks;
   urls_row_t   rows [8];

   urls_top #(.AUTO_FLOW_OPTION(1'b1)) dut (
      .clk_i(clk_i), .rst_n_i(rst_n_i), .addr_i(addr_i),
      .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o),
      .tx_count_i(tx_count_i), .tx_shift_busy_i(tx_shift_busy_i),
      .rx_push_i(rx_push_i), .rx_push_err_i(rx_push_err_i),
      .rx_pop_i(rx_pop_i), .rts_n_o(rts_n_o), .loop_rts_o(loop_rts_o),
      .irq_o(irq_o));

   urls_modem m (.clk_i(clk_i), .rst_n_i(rst_n_i), .rts_n_i(rts_n_o),
                 .push_o(rx_push_i), .push_err_o(rx_push_err_i));

   // 125 MHz clock
   initial begin
      clk_i = 1'b0;
      forever #4 clk_i = ~clk_i;
   end

   task automatic complete_run();
      $display("checks %0d mismatches %0d", total_checks, err_total);
      if (err_total == 0 && total_checks > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask

   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      total_checks++;
      if (got !== exp) begin
         err_total++;
         $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   task automatic cyc(input int n);
      repeat (n) @(posedge clk_i);
      #1;
   endtask

   // one-cycle write strobe
   task automatic wr(input logic [31:0] a, input logic [15:0] d);
      @(posedge clk_i);
      addr_i  <= a;
      wdata_i <= d;
      wr_i    <= 1'b1;
      @(posedge clk_i);
      wr_i <= 1'b0;
   endtask

   // read data only stands in the cycle after the strobe
   task automatic rc(input logic [31:0] a, input logic [15:0] exp);
      @(posedge clk_i);
      addr_i <= a;
      rd_i   <= 1'b1;
      @(posedge clk_i);
      rd_i <= 1'b0;
      #1;
      rv = rdata_o;
      chk(rv, exp);
   endtask

   task automatic setx(input logic [4:0] c, input logic b);
      @(posedge clk_i);
      tx_count_i      <= c;
      tx_shift_busy_i <= b;
   endtask

   task automatic pop();
      @(posedge clk_i);
      rx_pop_i <= 1'b1;
      @(posedge clk_i);
      rx_pop_i <= 1'b0;
   endtask

   // hang guard, well beyond the few hundred cycles the run needs
   initial begin
      repeat (20000) @(posedge clk_i);
      err_total++;
      complete_run();
   end

   initial begin
      {addr_i, wdata_i, wr_i, rd_i, tx_count_i} = '0;
      {tx_shift_busy_i, rx_pop_i, rst_n_i} = '0;
      err_total    = 0;
      total_checks = 0;
      // fcr, ier, mcr, tx count, shifter busy, rts_n, loop, lsr[7:5]
      rows[0] = {8'h00, 8'h00, 8'h02, 5'h00, 1'b0, 1'b0, 1'b0, 3'h3};
      rows[1] = {8'h00, 8'h00, 8'h00, 5'h00, 1'b1, 1'b1, 1'b0, 3'h1};
      rows[2] = {8'h00, 8'h00, 8'h12, 5'h03, 1'b0, 1'b1, 1'b1, 3'h0};
      rows[3] = {8'h01, 8'h00, 8'h22, 5'h03, 1'b1, 1'b0, 1'b0, 3'h0};
      rows[4] = {8'h01, 8'h80, 8'h02, 5'h10, 1'b0, 1'b0, 1'b0, 3'h1};
      rows[5] = {8'h01, 8'h80, 8'h02, 5'h05, 1'b0, 1'b0, 1'b0, 3'h0};
      rows[6] = {8'h00, 8'h80, 8'h02, 5'h10, 1'b0, 1'b0, 1'b0, 3'h0};
      rows[7] = {8'h00, 8'h00, 8'h20, 5'h00, 1'b0, 1'b1, 1'b0, 3'h3};
      repeat (2) @(posedge clk_i);
      rst_n_i <= 1'b1;
      cyc(1);
      chk(16'({rts_n_o, loop_rts_o, irq_o}), 16'h0004);
      rc(urls_pkg::LSR_ADDR, 16'h0060);
      wr(urls_pkg::LSR_ADDR, 16'h0000);
      rc(urls_pkg::LSR_ADDR, 16'h0060);
      rc(urls_pkg::MCR_ADDR, 16'h0000);
      rc(32'h5000_1000, 16'h0000);
      // pin, loopback and status flags for each register setting
      foreach (rows[i]) begin
         wr(urls_pkg::FCR_ADDR, {8'h00, rows[i].fifo_ctrl});
         wr(urls_pkg::IER_ADDR, {8'h00, rows[i].irq_enable_ctrl});
         wr(urls_pkg::MCR_ADDR, {8'h00, rows[i].modem_line_control});
         setx(rows[i].txc, rows[i].busy);
         cyc(3);
         chk(16'(rts_n_o), 16'(rows[i].rts_n));
         chk(16'(loop_rts_o), 16'(rows[i].loop));
         rc(urls_pkg::LSR_ADDR, {8'h00, rows[i].line_state_status, 5'h00});
         rc(urls_pkg::MCR_ADDR, {8'h00, rows[i].modem_line_control});
      end
      // auto flow: fill of 2 is above trigger 1, so the data set stalls
      setx(5'h00, 1'b0);
      wr(urls_pkg::FCR_ADDR, 16'h0001);
      wr(urls_pkg::MCR_ADDR, 16'h0022);
      fork
         m.send_chars(3, 8'h00, 4);
         begin
            cyc(30);
            chk(16'(rts_n_o), 16'h0001);
            chk(16'(m.sent), 16'h0002);
            pop();
            pop();
         end
      join
      chk(16'(m.sent), 16'h0003);
      pop();
      // error flag survives until the errored head is the last error
      wr(urls_pkg::MCR_ADDR, 16'h0002);
      wr(urls_pkg::ISTA_ADDR, 16'h0003);
      m.send_chars(2, 8'h02, 1);
      rc(urls_pkg::LSR_ADDR, 16'h00E0);
      rc(urls_pkg::ISTA_ADDR, 16'h0002);
      rc(urls_pkg::LSR_ADDR, 16'h00E0);
      pop();
      rc(urls_pkg::LSR_ADDR, 16'h00E0);
      rc(urls_pkg::LSR_ADDR, 16'h0060);
      pop();
      // holding-empty event: enabled, cleared, then masked
      setx(5'h01, 1'b0);
      wr(urls_pkg::IER_ADDR, 16'h0002);
      wr(urls_pkg::ISTA_ADDR, 16'h0003);
      wr(urls_pkg::IMSK_ADDR, 16'h0001);
      setx(5'h00, 1'b0);
      cyc(3);
      chk(16'(irq_o), 16'h0001);
      rc(urls_pkg::ISTA_ADDR, 16'h0001);
      wr(urls_pkg::ISTA_ADDR, 16'h0001);
      cyc(2);
      chk(16'(irq_o), 16'h0000);
      wr(urls_pkg::IMSK_ADDR, 16'h0000);
      setx(5'h01, 1'b0);
      cyc(2);
      setx(5'h00, 1'b0);
      cyc(3);
      chk(16'(irq_o), 16'h0000);
      rc(urls_pkg::ISTA_ADDR, 16'h0001);
      // threshold mode: trigger 4 fires at a count of exactly 4
      wr(urls_pkg::FCR_ADDR, 16'h0021);
      wr(urls_pkg::IER_ADDR, 16'h0082);
      setx(5'h06, 1'b0);
      cyc(3);
      wr(urls_pkg::ISTA_ADDR, 16'h0001);
      rc(urls_pkg::ISTA_ADDR, 16'h0000);
      setx(5'h04, 1'b0);
      cyc(3);
      rc(urls_pkg::ISTA_ADDR, 16'h0001);
      // mid-run reset with pin driven and interrupt raised
      wr(urls_pkg::MCR_ADDR, 16'h0002);
      wr(urls_pkg::IMSK_ADDR, 16'h0001);
      cyc(2);
      chk(16'({rts_n_o, loop_rts_o, irq_o}), 16'h0001);
      @(posedge clk_i);
      rst_n_i <= 1'b0;
      cyc(2);
      chk(16'({rts_n_o, loop_rts_o, irq_o}), 16'h0004);
      setx(5'h00, 1'b0);
      @(posedge clk_i);
      rst_n_i <= 1'b1;
      rc(urls_pkg::LSR_ADDR, 16'h0060);
      rc(urls_pkg::MCR_ADDR, 16'h0000);
      complete_run();
   end
endmodule
`default_nettype wire
